/* File: design/urbs_pkg.sv */
// ====================================================================
// Receive buffer constants
package urbs_pkg;

    // ================================================================
    // Register byte offsets on the APB
    localparam logic [7:0] OFF_STATUS_A = 8'h00;
    localparam logic [7:0] OFF_CONTROL_B = 8'h04;
    localparam logic [7:0] OFF_CONTROL_C = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_BAUD = 8'h10;

    // ================================================================
    // Field positions
    localparam int ST_DOUBLE = 1;
    localparam int ST_PE = 2;
    localparam int ST_DOR = 3;
    localparam int ST_FE = 4;
    localparam int ST_RXC = 7;
    localparam int CB_NINTH = 1;
    localparam int CB_SIZE2 = 2;
    localparam int CB_RX_ENABLE_BIT = 4;
    localparam int CB_IRQEN = 7;
    localparam int CC_SIZE_LO = 1;
    localparam int CC_STOP = 3;
    localparam int CC_PTYPE = 4;
    localparam int CC_PEN = 5;

    // ================================================================
    // Buffer entry: data, then frame, overrun, parity flags
    localparam int DATA_BITS = 9;
    localparam int BYTE_BITS = 8;
    localparam int CHAR_MIN = 5;
    localparam int ENT_FE = 9;
    localparam int ENT_DOR = 10;
    localparam int ENT_PE = 11;
    localparam int ENT_W = 12;

    // ================================================================
    // Size and sampling
    localparam logic [2:0] CS_NINE = 3'h7;
    localparam logic [2:0] CS_FIVE = 3'h0;
    localparam logic [2:0] CS_RESET = 3'h3;
    localparam logic [3:0] CHAR_BASE = 4'h5;
    localparam logic [3:0] NINE_BITS = 4'h9;
    localparam logic [4:0] SPB_NORMAL = 5'h10;
    localparam logic [4:0] SPB_DOUBLE = 5'h08;
    localparam logic [4:0] VOTE_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;
    localparam int BAUD_W = 12;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    // ================================================================
    // Receiver states
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} urbs_state_type;

endpackage : urbs_pkg

/* File: design/urbs_receiver.sv */
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Nine-bit mode: read ninth bit before data
// R2: Ninth bit and error flags stored per entry
// R3: Receive complete reflects unread buffered data
// R4: Receiver disable flushes buffer, clears complete
// R5: Level interrupt while complete, enabled globally
// R6: Handler must read data to clear
// R7: Read status before data location
// R8: Error flags ignore software writes
// R9: Error flags never raise interrupts
// R10: Frame error mirrors first stop bit
// R11: Stop count setting does not affect framing
// R12: Overrun when full, waiting, new start
// R13: Overrun clears on successful transfer
// R14: Parity checked, result stored with data
// R15: Parity error masked when checking disabled
// R16: Disable immediate, aborts reception, frees pin
// R17: Software flushes by reading data repeatedly
// R18: Clock recovery aligns, majority filters bits
// R19: First stop bit moves frame to buffer
// R20: Unused upper data bits read zero
// R21: Start vote on samples eight/four onward
// R22: Parity type zero even, one odd
module urbs_receiver
    import urbs_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial line
    input wire logic RXD,
    output logic RXD_OVERRIDE,
    // Interrupt request
    input wire logic GLOBAL_IRQ_EN,
    output logic RX_COMPLETE_IRQ
);
    localparam int CW = $clog2(DEPTH+1);

    // ================================================================
    // Configuration state
    logic rx_enable_bit;
    logic rx_complete_irq_en;
    logic double_speed_bit;
    logic parity_enable_bit;
    logic parity_type_bit;
    logic stop_bit_count_sel;
    logic [2:0] char_size_sel;
    logic [BAUD_W-1:0] baud_div;

    // Receiver state
    urbs_state_type state;
    urbs_state_type next_state;
    logic [4:0] samp_cnt;
    logic [4:0] next_cnt;
    logic [1:0] votes;
    logic [1:0] next_votes;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic [DATA_BITS-1:0] shift_data;
    logic [DATA_BITS-1:0] next_data;
    logic frame_pe;
    logic next_pe;
    logic frame_done;
    logic frame_fe;
    logic start_ok;
    logic pending_valid;
    logic [ENT_W-1:0] pending_entry;
    logic lost;
    logic rd_valid;

    // Sampler and buffer wires
    logic rx_level;
    logic tick;
    logic [ENT_W-1:0] head;
    logic [CW-1:0] fifo_count;
    logic fifo_empty;
    logic fifo_full;

    // ================================================================
    // APB decode
    wire logic acc_wait = PSEL && PENABLE && !PREADY;
    wire logic acc_done = PSEL && PENABLE && PREADY;
    wire logic sel_status = (PADDR == OFF_STATUS_A);
    wire logic sel_ctrl_b = (PADDR == OFF_CONTROL_B);
    wire logic sel_ctrl_c = (PADDR == OFF_CONTROL_C);
    wire logic sel_data = (PADDR == OFF_DATA);
    wire logic sel_baud = (PADDR == OFF_BAUD);
    wire logic mapped = sel_status || sel_ctrl_b || sel_ctrl_c || sel_data || sel_baud;
    wire logic wr_done = acc_done && PWRITE && !PSLVERR;
    // Pop only what the read latched
    wire logic pop = acc_done && !PWRITE && sel_data && rd_valid; // R2

    // Head fields, zero when empty
    wire logic rx_complete_flag = !fifo_empty; // R3
    wire logic rx_ninth_bit = rx_complete_flag && head[BYTE_BITS];
    wire logic frame_err_flag = rx_complete_flag && head[ENT_FE];
    wire logic overrun_flag = rx_complete_flag && head[ENT_DOR];
    wire logic parity_err_flag = rx_complete_flag && head[ENT_PE] && parity_enable_bit; // R15

    // ================================================================
    // Read word assembly
    logic [31:0] status_word;
    logic [31:0] ctrl_b_word;
    logic [31:0] ctrl_c_word;
    logic [31:0] data_word;
    logic [31:0] read_word;
    always_comb
    begin
        status_word = 32'h00000000;
        ctrl_b_word = 32'h00000000;
        ctrl_c_word = 32'h00000000;
        data_word = 32'h00000000;
        status_word[ST_RXC] = rx_complete_flag;
        status_word[ST_FE] = frame_err_flag;
        status_word[ST_DOR] = overrun_flag;
        status_word[ST_PE] = parity_err_flag;
        status_word[ST_DOUBLE] = double_speed_bit;
        ctrl_b_word[CB_IRQEN] = rx_complete_irq_en;
        ctrl_b_word[CB_RX_ENABLE_BIT] = rx_enable_bit;
        ctrl_b_word[CB_SIZE2] = char_size_sel[2];
        ctrl_b_word[CB_NINTH] = rx_ninth_bit; // R1
        ctrl_c_word[CC_PEN] = parity_enable_bit;
        ctrl_c_word[CC_PTYPE] = parity_type_bit;
        ctrl_c_word[CC_STOP] = stop_bit_count_sel;
        ctrl_c_word[CC_SIZE_LO+1:CC_SIZE_LO] = char_size_sel[1:0];
        // Short characters leave upper bits zero
        data_word[BYTE_BITS-1:0] = rx_complete_flag ? head[BYTE_BITS-1:0] : 8'h00; // R20
    end
    assign read_word = sel_status ? status_word :
                       sel_ctrl_b ? ctrl_b_word :
                       sel_ctrl_c ? ctrl_c_word :
                       sel_data ? data_word :
                       sel_baud ? {{(32-BAUD_W){1'b0}}, baud_div} : 32'h00000000;

    // ================================================================
    // One wait state; read data latched then
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            PREADY <= 1'h0;
            PSLVERR <= 1'h0;
            PRDATA <= 32'h00000000;
            rd_valid <= 1'h0;
        end
        else
        begin
            PREADY <= acc_wait;
            PSLVERR <= acc_wait && !mapped;
            if (acc_wait && !PWRITE)
                PRDATA <= read_word;
            rd_valid <= acc_wait && rx_complete_flag;
        end
    end

    // Writes; error flags have no write path
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            rx_enable_bit <= 1'h0;
            rx_complete_irq_en <= 1'h0;
            double_speed_bit <= 1'h0;
            parity_enable_bit <= 1'h0;
            parity_type_bit <= 1'h0;
            stop_bit_count_sel <= 1'h0;
            char_size_sel <= CS_RESET;
            baud_div <= BAUD_RESET;
        end
        else if (wr_done)
        begin
            if (sel_status)
                double_speed_bit <= PWDATA[ST_DOUBLE]; // R8
            if (sel_ctrl_b)
            begin
                rx_complete_irq_en <= PWDATA[CB_IRQEN];
                rx_enable_bit <= PWDATA[CB_RX_ENABLE_BIT];
                char_size_sel[2] <= PWDATA[CB_SIZE2];
            end
            if (sel_ctrl_c)
            begin
                parity_enable_bit <= PWDATA[CC_PEN];
                parity_type_bit <= PWDATA[CC_PTYPE];
                stop_bit_count_sel <= PWDATA[CC_STOP];
                char_size_sel[1:0] <= PWDATA[CC_SIZE_LO+1:CC_SIZE_LO];
            end
            if (sel_baud)
                baud_div <= PWDATA[BAUD_W-1:0];
        end
    end

    // ================================================================
    // Sampling geometry for the current speed
    wire logic [4:0] spb = double_speed_bit ? SPB_DOUBLE : SPB_NORMAL;
    wire logic [4:0] vote_first = double_speed_bit ? VOTE_DOUBLE : VOTE_NORMAL;
    wire logic [4:0] vote_last = vote_first + VOTE_SPAN;
    wire logic [4:0] cur = samp_cnt + 5'h01;
    wire logic in_vote = (cur >= vote_first) && (cur <= vote_last);
    wire logic bit_decide = tick && (cur == vote_last); // R21
    wire logic bit_end = tick && (cur == spb);
    // Three-sample majority is the low pass filter
    wire logic maj = (votes[1] && votes[0]) || (votes[1] && rx_level) ||
                     (votes[0] && rx_level); // R18
    wire logic [3:0] nbits = (char_size_sel == CS_NINE) ? NINE_BITS :
                             {2'b00, char_size_sel[1:0]} + CHAR_BASE;

    urbs_sampler #(.DIV_W(BAUD_W)) u_sampler (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .rxd_pin(RXD),
        .enable(rx_enable_bit),
        .hunt(state == RX_IDLE),
        .divisor(baud_div),
        .level(rx_level),
        .tick(tick)
    );

    // Frame FSM, counted from first low sample
    always_comb
    begin
        next_state = state;
        next_cnt = samp_cnt;
        next_votes = votes;
        next_bit_idx = bit_idx;
        next_data = shift_data;
        next_pe = frame_pe;
        frame_done = 1'b0;
        frame_fe = 1'b0;
        start_ok = 1'b0;
        if (tick)
        begin
            next_cnt = bit_end ? 5'h00 : cur;
            if (in_vote)
                next_votes = {votes[0], rx_level};
        end
        case (state)
            RX_IDLE:
            begin
                next_cnt = 5'h00;
                if (tick && !rx_level)
                begin
                    next_state = RX_START;
                    next_cnt = 5'h01;
                    next_bit_idx = 4'h0;
                    next_data = '0;
                    next_pe = 1'b0;
                end
            end
            RX_START:
            begin
                if (bit_decide && maj)
                    next_state = RX_IDLE; // R21
                else if (bit_decide)
                    start_ok = 1'b1;
                if (bit_end)
                    next_state = RX_DATA;
            end
            RX_DATA:
            begin
                if (bit_decide)
                    next_data[bit_idx] = maj;
                if (bit_end && bit_idx == nbits - 4'h1)
                    next_state = parity_enable_bit ? RX_PARITY : RX_STOP;
                else if (bit_end)
                    next_bit_idx = bit_idx + 4'h1;
            end
            RX_PARITY:
            begin
                // Error when parity misses the chosen sense
                if (bit_decide)
                    next_pe = parity_enable_bit && ((^shift_data) ^ maj ^ parity_type_bit); // R14 R22
                if (bit_end)
                    next_state = RX_STOP;
            end
            RX_STOP:
            begin
                // Only the first stop bit counts
                if (bit_decide)
                begin
                    frame_done = 1'b1; // R19
                    frame_fe = !maj; // R10 R11
                    next_state = RX_IDLE;
                end
            end
            default:
                next_state = RX_IDLE;
        endcase
    end

    // Disable aborts any frame at once
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || !rx_enable_bit)
        begin
            state <= RX_IDLE; // R16
            samp_cnt <= 5'h00;
            votes <= 2'h0;
            bit_idx <= 4'h0;
            shift_data <= '0;
            frame_pe <= 1'h0;
        end
        else
        begin
            state <= next_state;
            samp_cnt <= next_cnt;
            votes <= next_votes;
            bit_idx <= next_bit_idx;
            shift_data <= next_data;
            frame_pe <= next_pe;
        end
    end

    // ================================================================
    // Hand-off; overrun marks the waiting frame
    wire logic fifo_push = pending_valid && !fifo_full;
    wire logic load_pending = frame_done && (!pending_valid || fifo_push);
    wire logic [ENT_W-1:0] push_entry = {pending_entry[ENT_W-1:ENT_DOR+1], lost,
                                         pending_entry[ENT_DOR-1:0]};
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || !rx_enable_bit)
        begin
            pending_valid <= 1'h0;
            pending_entry <= '0;
            lost <= 1'h0;
        end
        else
        begin
            pending_valid <= load_pending || (pending_valid && !fifo_push);
            if (load_pending)
                pending_entry <= {frame_pe, 1'b0, frame_fe, shift_data}; // R2
            // A new overrun outranks the clear
            if (start_ok && pending_valid && fifo_full)
                lost <= 1'h1; // R12
            else if (fifo_push)
                lost <= 1'h0; // R13
        end
    end

    urbs_rx_fifo #(.WIDTH(ENT_W), .DEPTH(DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .flush(!rx_enable_bit),
        .push(fifo_push),
        .push_data(push_entry),
        .pop(pop),
        .head(head),
        .count(fifo_count),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // Level request and pin ownership
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            RX_COMPLETE_IRQ <= 1'h0;
            RXD_OVERRIDE <= 1'h0;
        end
        else
        begin
            RX_COMPLETE_IRQ <= rx_complete_irq_en && GLOBAL_IRQ_EN && rx_complete_flag; // R5 R9
            RXD_OVERRIDE <= rx_enable_bit; // R16
        end
    end

    // ================================================================
    // Assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_apb_wait;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_status_read;
        s_apb_wait and (sel_status && !PWRITE);
    endsequence

    a_apb_one_wait: assert property (s_apb_wait |=> PREADY)
        else $error("APB answer not after one wait");
    a_rxc_status: assert property (s_status_read |=> PRDATA[ST_RXC] == $past(!fifo_empty)) // R3
        else $error("Complete flag wrong");
    a_flush_disable: assert property (!rx_enable_bit |=> fifo_empty) // R4
        else $error("Buffer not flushed on disable");
    a_abort_frame: assert property (!rx_enable_bit |=> state == RX_IDLE && !pending_valid) // R16
        else $error("Reception survives disable");
    a_irq_level: assert property (rx_complete_irq_en && GLOBAL_IRQ_EN && !fifo_empty
        |=> RX_COMPLETE_IRQ) // R5
        else $error("Interrupt request missing");
    a_irq_no_err: assert property (fifo_empty |=> !RX_COMPLETE_IRQ) // R9
        else $error("Interrupt without received data");
    a_pop_advance: assert property (pop && !fifo_push
        |=> fifo_count == $past(fifo_count) - CW'(1)) // R2
        else $error("Data read kept buffer");
    a_overrun_set: assert property (start_ok && pending_valid && fifo_full |=> lost) // R12
        else $error("Overrun not flagged");
    a_overrun_clear: assert property (fifo_push && !start_ok |=> !lost) // R13
        else $error("Overrun not cleared on transfer");
    a_frame_err: assert property (load_pending
        |=> pending_entry[ENT_FE] == $past(frame_fe) && pending_valid) // R10
        else $error("Frame error not stored");
    a_pe_masked: assert property (s_status_read and !parity_enable_bit |=> !PRDATA[ST_PE]) // R15
        else $error("Parity error while disabled");
    a_upper_zero: assert property (s_apb_wait and (sel_data && !PWRITE && char_size_sel == CS_FIVE)
        |=> PRDATA[BYTE_BITS-1:CHAR_MIN] == 3'h0) // R20
        else $error("Unused data bits not zero");
    a_start_reject: assert property (state == RX_START && bit_decide && maj |=> state == RX_IDLE) // R21
        else $error("Noise start bit accepted");

endmodule : urbs_receiver
`default_nettype wire

/* File: design/urbs_rx_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// Receive buffer of characters and flags
module urbs_rx_fifo
    import urbs_pkg::*;
#(
    parameter int WIDTH = ENT_W,
    parameter int DEPTH = 2
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    // State
    output logic [WIDTH-1:0] head,
    output logic [$clog2(DEPTH+1)-1:0] count,
    output logic empty,
    output logic full
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;

    // Full push dropped; caller holds it back
    wire logic do_push = push && !full;
    wire logic do_pop = pop && !empty;
    assign empty = (count == '0);
    assign full = (count == CW'(DEPTH));
    assign head = mem[rd_ptr];

    // Pointers and level; flush empties at once
    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
            if (do_pop)
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
            if (do_push && !do_pop)
                count <= count + ONE;
            else if (do_pop && !do_push)
                count <= count - ONE;
        end
    end

    // No reset; count guards reads
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wr_ptr] <= push_data;
    end

endmodule : urbs_rx_fifo
`default_nettype wire

/* File: design/urbs_sampler.sv */
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// Pin synchroniser, glitch filter and oversampling tick
module urbs_sampler
    import urbs_pkg::*;
#(
    parameter int DIV_W = BAUD_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and control
    input wire logic rxd_pin,
    input wire logic enable,
    input wire logic hunt,
    input wire logic [DIV_W-1:0] divisor,
    // Recovered level and sample tick
    output logic level,
    output logic tick
);
    logic s1;
    logic s2;
    logic s3;
    logic [DIV_W-1:0] cnt;

    // Level changes only once the last two stages agree
    wire logic agree = (s2 == s3);
    // Start edge realigns the sample clock
    wire logic fall = hunt && level && agree && !s3;

    // Three-flop synchroniser
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1 <= 1'h1;
            s2 <= 1'h1;
            s3 <= 1'h1;
            level <= 1'h1;
        end
        else
        begin
            s1 <= rxd_pin;
            s2 <= s1;
            s3 <= s2;
            if (agree)
                level <= s3;
        end
    end

    // Tick divider
    always_ff @(posedge clk)
    begin
        if (!rst_n || !enable)
        begin
            cnt <= '0;
            tick <= 1'h0;
        end
        else if (fall || cnt == divisor)
        begin
            cnt <= '0;
            tick <= 1'h1;
        end
        else
        begin
            cnt <= cnt + DIV_W'(1);
            tick <= 1'h0;
        end
    end

endmodule : urbs_sampler
`default_nettype wire

/* File: tb/uart_receive_buffer_status_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
// ====
// Bench: APB master plus remote transmitter
module uart_receive_buffer_status_tb;
    import urbs_pkg::*;
    logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, GLOBAL_IRQ_EN, err, send, sbad, busy;
    logic PREADY, PSLVERR, RXD, RXD_OVERRIDE, RX_COMPLETE_IRQ;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [8:0] sdata;
    logic [3:0] nb;
    logic [1:0] par;
    logic [4:0] bclk;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    urbs_receiver #(.DEPTH(2)) dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .RXD_OVERRIDE(RXD_OVERRIDE),
        .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .RX_COMPLETE_IRQ(RX_COMPLETE_IRQ));
    urbs_tx_model tx_u (.clk(REF_CLK), .send(send), .data(sdata), .nbits(nb), .par(par),
        .stop_bad(sbad), .bclk(bclk), .txd(RXD), .busy(busy));
    // Clock and watchdog
    initial
    begin
        REF_CLK = 1'h0;
        forever #20 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_fail++;
            close_out();
        end
    end
    // One APB transfer, held until PREADY
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge REF_CLK);
        PENABLE <= 1'h1;
        @(posedge REF_CLK);
        while (PREADY !== 1'h1) @(posedge REF_CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge REF_CLK);
    endtask : apb
    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk
    // Frame, then a gap for the push
    task frame(input logic [8:0] d, input logic bad);
        sdata <= d;
        sbad <= bad;
        send <= 1'h1;
        @(posedge REF_CLK);
        send <= 1'h0;
        @(posedge REF_CLK);
        while (busy === 1'h1) @(posedge REF_CLK);
        repeat (4) @(posedge REF_CLK);
    endtask : frame
    task t_reset;
        rchk(OFF_STATUS_A, 32'h0);
        rchk(8'h14, 32'h0);
        `CHK(err, 1'h1)
        `CHK(RXD_OVERRIDE, 1'h0)
    endtask : t_reset
    task t_basic;
        apb(1'h1, OFF_CONTROL_B, 32'h90);
        frame(9'h0A5, 1'h0);
        `CHK(RX_COMPLETE_IRQ, 1'h0)
        GLOBAL_IRQ_EN <= 1'h1;
        repeat (3) @(posedge REF_CLK);
        `CHK(RX_COMPLETE_IRQ, 1'h1)
        `CHK(RXD_OVERRIDE, 1'h1)
        rchk(OFF_STATUS_A, 32'h80);
        rchk(OFF_DATA, 32'hA5);
        repeat (3) @(posedge REF_CLK);
        `CHK(RX_COMPLETE_IRQ, 1'h0)
    endtask : t_basic
    task t_frame;
        apb(1'h1, OFF_CONTROL_C, 32'h0E);
        frame(9'h03C, 1'h1);
        rchk(OFF_STATUS_A, 32'h90);
        apb(1'h1, OFF_STATUS_A, 32'h1C);
        rchk(OFF_STATUS_A, 32'h90);
        rchk(OFF_DATA, 32'h3C);
        frame(9'h0C3, 1'h0);
        rchk(OFF_STATUS_A, 32'h80);
        rchk(OFF_DATA, 32'hC3);
    endtask : t_frame
    // Bad then good parity, each type
    task t_parity;
        nb <= 4'h7;
        for (int t = 0; t < 2; t++)
        begin
            apb(1'h1, OFF_CONTROL_C, {26'h0, 1'h1, t[0], 4'h4});
            par <= {1'h1, ~t[0]};
            frame(9'h0D5, 1'h0);
            par <= {1'h1, t[0]};
            frame(9'h0D5, 1'h0);
            rchk(OFF_STATUS_A, 32'h84);
            apb(1'h1, OFF_CONTROL_C, 32'h04);
            rchk(OFF_STATUS_A, 32'h80);
            apb(1'h1, OFF_CONTROL_C, {26'h0, 1'h1, t[0], 4'h4});
            rchk(OFF_DATA, 32'h55);
            rchk(OFF_STATUS_A, 32'h80);
            rchk(OFF_DATA, 32'h55);
        end
        par <= 2'h0;
    endtask : t_parity
    task t_nine;
        apb(1'h1, OFF_STATUS_A, 32'h02);
        apb(1'h1, OFF_CONTROL_C, 32'h06);
        apb(1'h1, OFF_CONTROL_B, 32'h94);
        bclk <= 5'h08;
        nb <= 4'h9;
        frame(9'h1A5, 1'h0);
        rchk(OFF_STATUS_A, 32'h82);
        rchk(OFF_CONTROL_B, 32'h96);
        rchk(OFF_DATA, 32'hA5);
        rchk(OFF_CONTROL_B, 32'h94);
        apb(1'h1, OFF_STATUS_A, 32'h00);
        apb(1'h1, OFF_CONTROL_B, 32'h90);
        bclk <= 5'h10;
        nb <= 4'h8;
    endtask : t_nine
    // Four unread frames: third overrun, fourth lost
    task t_overrun;
        for (int i = 1; i < 5; i++) frame(9'(i * 17), 1'h0);
        for (int i = 1; i < 4; i++)
        begin
            rchk(OFF_STATUS_A, (i == 3) ? 32'h88 : 32'h80);
            rchk(OFF_DATA, 32'(i * 17));
        end
        rchk(OFF_STATUS_A, 32'h00);
        frame(9'h05A, 1'h0);
        frame(9'h05B, 1'h0);
        rchk(OFF_STATUS_A, 32'h80);
        apb(1'h1, OFF_CONTROL_B, 32'h80);
        rchk(OFF_STATUS_A, 32'h00);
        `CHK(RXD_OVERRIDE, 1'h0)
        `CHK(RX_COMPLETE_IRQ, 1'h0)
    endtask : t_overrun
    task close_out;
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // Main sequence
    initial
    begin
        {RST_N, PSEL, PENABLE, PWRITE, GLOBAL_IRQ_EN, send, sbad} = 7'h0;
        PADDR = 8'h0;
        PWDATA = 32'h0;
        sdata = 9'h0;
        nb = 4'h8;
        par = 2'h0;
        bclk = 5'h10;
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'h1;
        @(posedge REF_CLK);
        t_reset();
        t_basic();
        t_frame();
        t_parity();
        t_nine();
        t_overrun();
        close_out();
    end
endmodule : uart_receive_buffer_status_tb
`default_nettype wire

/* File: tb/urbs_tx_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// Remote transmitter, LSB first, idle high
module urbs_tx_model
(
    // Clock and request
    input wire logic clk,
    input wire logic send,
    input wire logic [8:0] data,
    input wire logic [3:0] nbits,
    input wire logic [1:0] par,
    input wire logic stop_bad,
    input wire logic [4:0] bclk,
    // Line and status
    output logic txd,
    output logic busy
);
    logic p;
    // par[1] adds parity, par[0] picks odd
    initial
    begin
        txd = 1'h1;
        busy = 1'h0;
        forever
        begin
            @(posedge clk);
            if (send === 1'h1)
            begin
                busy <= 1'h1;
                p = par[0];
                txd <= 1'h0;
                repeat (bclk) @(posedge clk);
                for (int i = 0; i < nbits; i++)
                begin
                    p = p ^ data[i];
                    txd <= data[i];
                    repeat (bclk) @(posedge clk);
                end
                if (par[1])
                begin
                    txd <= p;
                    repeat (bclk) @(posedge clk);
                end
                // Bad stop drives low, then one idle bit
                txd <= ~stop_bad;
                repeat (bclk) @(posedge clk);
                txd <= 1'h1;
                repeat (bclk) @(posedge clk);
                busy <= 1'h0;
            end
        end
    end
endmodule : urbs_tx_model
`default_nettype wire
